/* src/eisa_cycle_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Bus clock side: frames cycles and latches address and byte enables
// ============================================================================
module eisa_link_front #(
  parameter logic [eisa_cycle_pkg::ADDR_W-1:0] IO_BASE        = eisa_cycle_pkg::IO_BASE_DEF,
  parameter logic [eisa_cycle_pkg::ADDR_W-1:0] IO_MASK        = eisa_cycle_pkg::IO_MASK_DEF,
  parameter logic [eisa_cycle_pkg::ADDR_W-1:0] MEM_BASE       = eisa_cycle_pkg::MEM_BASE_DEF,
  parameter logic [eisa_cycle_pkg::ADDR_W-1:0] MEM_MASK       = eisa_cycle_pkg::MEM_MASK_DEF,
  parameter bit                                USE_BALE_LATCH = 1'b0
) (
  input  wire logic                       bclk_i,
  input  wire logic                       rst_n_i,
  input  wire eisa_cycle_pkg::link_pins_s pins_i,
  output eisa_cycle_pkg::cycle_s          payload_o,
  output logic                            tog_o,
  output logic                            busy_o
);
  import eisa_cycle_pkg::*;

  link_state_s       r_reg;
  link_state_s       r_next;
  logic [ADDR_W-1:0] dec_addr;
  logic              hit;
  logic              cmd_lead;

  function automatic logic in_window(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] base,
                                     input logic [ADDR_W-1:0] mask);
    in_window = ((a ^ base) & mask) == '0;
  endfunction

  // The pins are synchronous to the bus clock, so they are sampled directly.
  // CMD is only ever sampled here; the card has no driver for it.
  assign cmd_lead = (r_reg.st == L_START) && pins_i.start_n && !pins_i.cmd_n;
  assign dec_addr = USE_BALE_LATCH ? r_reg.bale_addr : r_reg.cap_addr;
  // Address enable is looked at on the CMD edge, after the board has let it fall.
  assign hit = r_reg.cap_mem ? in_window(dec_addr, MEM_BASE, MEM_MASK)
                             : (!pins_i.aen && in_window(dec_addr, IO_BASE, IO_MASK));

  always_comb begin
    r_next = r_reg;
    r_next.rst_sync = {r_reg.rst_sync[1:0], rst_n_i};
    if (r_reg.rst_sync[1] && r_reg.rst_sync[2]) begin
      r_next.lrst_n = 1'b1;
    end else if (!r_reg.rst_sync[1] && !r_reg.rst_sync[2]) begin
      r_next.lrst_n = 1'b0;
    end
    // The flag is unknown at power up; testing it this way round sends that
    // case down the reset path, so the bus side never runs on unknown state.
    if (r_reg.lrst_n) begin
      // Clocked stand-in for a transparent latch: follows while BALE is high
      // and holds from its trailing edge, which also covers BALE held for DMA.
      if (pins_i.bale) begin
        r_next.bale_addr = pins_i.la;
      end
      case (r_reg.st)
        L_IDLE: begin
          if (!pins_i.start_n) begin
            r_next.cap_addr = pins_i.la;
            r_next.cap_be   = ~pins_i.be_n;
            r_next.cap_wr   = pins_i.wr;
            r_next.cap_mem  = pins_i.mio;
            r_next.st       = L_START;
          end
        end
        L_START: begin
          if (!pins_i.start_n) begin
            // Keep following while START is low; the last sample is the one
            // taken just before its trailing edge.
            r_next.cap_addr = pins_i.la;
            r_next.cap_be   = ~pins_i.be_n;
            r_next.cap_wr   = pins_i.wr;
            r_next.cap_mem  = pins_i.mio;
          end else if (cmd_lead) begin
            r_next.st = L_CMD;
            if (hit) begin
              r_next.payload.write = r_reg.cap_wr;
              r_next.payload.mem   = r_reg.cap_mem;
              r_next.payload.addr  = dec_addr;
              r_next.payload.be    = r_reg.cap_be;
              r_next.tog           = ~r_reg.tog;
            end
          end else begin
            r_next.st = L_IDLE;
          end
        end
        L_CMD: begin
          // No cycle counter: the cycle lasts as long as CMD is seen low,
          // however far the board stretches the bus clock.
          if (pins_i.cmd_n) begin
            if (!pins_i.start_n) begin
              r_next.cap_addr = pins_i.la;
              r_next.cap_be   = ~pins_i.be_n;
              r_next.cap_wr   = pins_i.wr;
              r_next.cap_mem  = pins_i.mio;
              r_next.st       = L_START;
            end else begin
              r_next.st = L_IDLE;
            end
          end
        end
        default: begin
          r_next.st = L_IDLE;
        end
      endcase
    end else begin
      r_next.st        = L_IDLE;
      r_next.cap_addr  = ADDR_RST;
      r_next.bale_addr = ADDR_RST;
      r_next.cap_be    = BE_RST;
      r_next.cap_wr    = 1'b0;
      r_next.cap_mem   = 1'b0;
      r_next.payload   = CYCLE_RST;
      r_next.tog       = 1'b0;
    end
    // Busy is registered so the far synchroniser never sees a decode glitch.
    r_next.busy = (r_next.st == L_CMD);
  end

  always_ff @(posedge bclk_i) begin
    r_reg <= r_next;
  end

  assign payload_o = r_reg.payload;
  assign tog_o     = r_reg.tog;
  assign busy_o    = r_reg.busy;

  // ==========================================================================
  // Checks on the bus clock side
  // ==========================================================================
  // The system reset is low from power up, while the local flag is still
  // unknown, so it keeps these checks quiet until the bus side is settled.
  property p_aen_blocks_io;
    @(posedge bclk_i) disable iff (!rst_n_i || !r_reg.lrst_n)
      (cmd_lead && !r_reg.cap_mem && pins_i.aen) |=> $stable(r_reg.tog);
  endproperty
  a_aen_blocks_io: assert property (p_aen_blocks_io)
    else $error("I/O cycle accepted while address enable was high.");

  property p_latch_at_cmd;
    @(posedge bclk_i) disable iff (!rst_n_i || !r_reg.lrst_n)
      (cmd_lead && hit) |=> (r_reg.payload.addr == $past(dec_addr))
                            && (r_reg.tog != $past(r_reg.tog));
  endproperty
  a_latch_at_cmd: assert property (p_latch_at_cmd)
    else $error("Address not taken on the CMD leading edge.");

  property p_bale_hold;
    @(posedge bclk_i) disable iff (!rst_n_i || !r_reg.lrst_n)
      (!pins_i.bale && !$past(pins_i.bale)) |=> $stable(r_reg.bale_addr);
  endproperty
  a_bale_hold: assert property (p_bale_hold)
    else $error("BALE address moved after the trailing edge.");

  property p_be_held;
    @(posedge bclk_i) disable iff (!rst_n_i || !r_reg.lrst_n)
      (r_reg.st == L_CMD) ##1 (r_reg.st == L_CMD) |-> $stable(r_reg.payload.be);
  endproperty
  a_be_held: assert property (p_be_held)
    else $error("Latched byte enables changed inside the cycle.");

  property p_stretch;
    @(posedge bclk_i) disable iff (!rst_n_i || !r_reg.lrst_n)
      (r_reg.st == L_CMD && !pins_i.cmd_n) |=> (r_reg.st == L_CMD);
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("Cycle closed while CMD was still low.");

  property p_cmd_end;
    @(posedge bclk_i) disable iff (!rst_n_i || !r_reg.lrst_n)
      (r_reg.st == L_CMD && pins_i.cmd_n) |=> (r_reg.st != L_CMD) && !busy_o;
  endproperty
  a_cmd_end: assert property (p_cmd_end)
    else $error("Cycle not closed after CMD went high.");

  property p_start_capture;
    @(posedge bclk_i) disable iff (!rst_n_i || !r_reg.lrst_n)
      (r_reg.st == L_IDLE && !pins_i.start_n)
        |=> (r_reg.st == L_START) && (r_reg.cap_be == ~$past(pins_i.be_n));
  endproperty
  a_start_capture: assert property (p_start_capture)
    else $error("Byte enables not captured while START was low.");

  property p_tog_at_cmd;
    @(posedge bclk_i) disable iff (!rst_n_i || !r_reg.lrst_n)
      !cmd_lead |=> $stable(r_reg.tog);
  endproperty
  a_tog_at_cmd: assert property (p_tog_at_cmd)
    else $error("Cycle accepted away from the CMD leading edge.");

  property p_abort;
    @(posedge bclk_i) disable iff (!rst_n_i || !r_reg.lrst_n)
      (r_reg.st == L_START && pins_i.start_n && pins_i.cmd_n)
        |=> (r_reg.st == L_IDLE) && $stable(r_reg.tog);
  endproperty
  a_abort: assert property (p_abort)
    else $error("Cycle without CMD was not dropped.");

  property p_mem_no_aen;
    @(posedge bclk_i) disable iff (!rst_n_i || !r_reg.lrst_n)
      (cmd_lead && r_reg.cap_mem && in_window(dec_addr, MEM_BASE, MEM_MASK))
        |=> (r_reg.tog != $past(r_reg.tog));
  endproperty
  a_mem_no_aen: assert property (p_mem_no_aen)
    else $error("Memory cycle refused by address enable.");

endmodule

// ============================================================================
// System clock side: top level
// ============================================================================
module eisa_cycle_ctrl #(
  parameter logic [eisa_cycle_pkg::ADDR_W-1:0] IO_BASE        = eisa_cycle_pkg::IO_BASE_DEF,
  parameter logic [eisa_cycle_pkg::ADDR_W-1:0] IO_MASK        = eisa_cycle_pkg::IO_MASK_DEF,
  parameter logic [eisa_cycle_pkg::ADDR_W-1:0] MEM_BASE       = eisa_cycle_pkg::MEM_BASE_DEF,
  parameter logic [eisa_cycle_pkg::ADDR_W-1:0] MEM_MASK       = eisa_cycle_pkg::MEM_MASK_DEF,
  parameter bit                                USE_BALE_LATCH = 1'b0
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       bclk_i,
  input  wire eisa_cycle_pkg::link_pins_s pins_i,
  output logic                            cyc_valid_o,
  output eisa_cycle_pkg::cycle_s          cyc_o,
  output logic                            busy_o
);
  import eisa_cycle_pkg::*;

  if (CLK_KHZ < CLK_PER_BCLK_MIN * BCLK_MAX_KHZ) begin : g_rate_chk
    $error("System clock too slow for the bus clock crossing.");
  end
  if (BCLK_MIN_KHZ > BCLK_MAX_KHZ) begin : g_bclk_chk
    $error("Bus clock range is inverted.");
  end

  sys_state_s r_reg;
  sys_state_s r_next;
  cycle_s     link_payload;
  logic       link_tog;
  logic       link_busy;
  logic       ev;

  eisa_link_front #(
    .IO_BASE        (IO_BASE),
    .IO_MASK        (IO_MASK),
    .MEM_BASE       (MEM_BASE),
    .MEM_MASK       (MEM_MASK),
    .USE_BALE_LATCH (USE_BALE_LATCH)
  ) u_front (
    .bclk_i    (bclk_i),
    .rst_n_i   (rst_n_i),
    .pins_i    (pins_i),
    .payload_o (link_payload),
    .tog_o     (link_tog),
    .busy_o    (link_busy)
  );

  // The payload stands still from the toggle until the next accepted cycle,
  // at least two bus clocks later, so it is settled once the toggle is seen.
  assign ev = (r_reg.tog_sync[1] == r_reg.tog_sync[2]) && (r_reg.tog_sync[2] != r_reg.acc);

  always_comb begin
    r_next = r_reg;
    r_next.tog_sync  = {r_reg.tog_sync[1:0], link_tog};
    r_next.busy_sync = {r_reg.busy_sync[1:0], link_busy};
    r_next.valid     = 1'b0;
    if (!rst_n_i) begin
      r_next.tog_sync  = 3'h0;
      r_next.busy_sync = 3'h0;
      r_next.acc       = 1'b0;
      r_next.busy      = 1'b0;
      r_next.cyc       = CYCLE_RST;
    end else begin
      if (r_reg.busy_sync[1] == r_reg.busy_sync[2]) begin
        r_next.busy = r_reg.busy_sync[2];
      end
      if (ev) begin
        r_next.acc   = r_reg.tog_sync[2];
        r_next.valid = 1'b1;
        r_next.cyc   = link_payload;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    r_reg <= r_next;
  end

  assign cyc_valid_o = r_reg.valid;
  assign cyc_o       = r_reg.cyc;
  assign busy_o      = r_reg.busy;

  // ==========================================================================
  // Checks on the system clock side
  // ==========================================================================
  property p_deliver;
    @(posedge clk_i) disable iff (!rst_n_i)
      ev |=> cyc_valid_o ##1 (!cyc_valid_o && $stable(cyc_o));
  endproperty
  a_deliver: assert property (p_deliver)
    else $error("Accepted cycle not delivered as a single pulse.");

  property p_cyc_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      !ev |=> $stable(cyc_o);
  endproperty
  a_cyc_hold: assert property (p_cyc_hold)
    else $error("Cycle data moved without a new accepted cycle.");

endmodule

`default_nettype wire

/* shared/eisa_cycle_pkg.sv */
package eisa_cycle_pkg;

  // ==========================================================================
  // Widths and field layout
  // ==========================================================================
  localparam int ADDR_LSB = 2;
  localparam int ADDR_W   = 30;
  localparam int BE_W     = 4;

  // ==========================================================================
  // Clock rates
  // ==========================================================================
  localparam int CLK_KHZ       = 100000;
  localparam int BCLK_MAX_KHZ  = 8333;
  localparam int BCLK_MIN_KHZ  = 6000;
  // The crossing needs several system clocks per bus clock.
  localparam int CLK_PER_BCLK_MIN = 4;

  // ==========================================================================
  // Decode window defaults
  // ==========================================================================
  localparam logic [ADDR_W-1:0] IO_BASE_DEF  = 30'h0000_0100;
  localparam logic [ADDR_W-1:0] IO_MASK_DEF  = 30'h0000_3ff0;
  localparam logic [ADDR_W-1:0] MEM_BASE_DEF = 30'h0040_0000;
  localparam logic [ADDR_W-1:0] MEM_MASK_DEF = 30'h3ffc_0000;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [ADDR_W-1:0] ADDR_RST = 30'h0000_0000;
  localparam logic [BE_W-1:0]   BE_RST   = 4'h0;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    L_IDLE  = 2'b00,
    L_START = 2'b01,
    L_CMD   = 2'b10
  } lstate_e;

  typedef struct packed {
    logic              write;
    logic              mem;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0]   be;
  } cycle_s;

  typedef struct packed {
    logic                 start_n;
    logic                 cmd_n;
    logic                 aen;
    logic                 bale;
    logic                 mio;
    logic                 wr;
    logic [BE_W-1:0]      be_n;
    logic [31:ADDR_LSB]   la;
  } link_pins_s;

  typedef struct packed {
    logic [2:0]        rst_sync;
    logic              lrst_n;
    lstate_e           st;
    logic [ADDR_W-1:0] cap_addr;
    logic [ADDR_W-1:0] bale_addr;
    logic [BE_W-1:0]   cap_be;
    logic              cap_wr;
    logic              cap_mem;
    cycle_s            payload;
    logic              tog;
    logic              busy;
  } link_state_s;

  typedef struct packed {
    logic [2:0] tog_sync;
    logic [2:0] busy_sync;
    logic       acc;
    logic       busy;
    logic       valid;
    cycle_s     cyc;
  } sys_state_s;

  localparam cycle_s CYCLE_RST = '{write: 1'b0, mem: 1'b0, addr: ADDR_RST, be: BE_RST};

endpackage

/* test/eisa_board_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// System board stand-in: bus clock and cycle framing
// ============================================================================
module eisa_board_model (
  output logic                       bclk_o,
  output eisa_cycle_pkg::link_pins_s pins_o
);
  import eisa_cycle_pkg::*;

  logic stretch;

  // The low phase grows by half a period while stretch is set, as compressed cycles do.
  initial begin
    bclk_o = 1'b0;
    stretch = 1'b0;
    pins_o = '{start_n: 1'b1, cmd_n: 1'b1, aen: 1'b1, bale: 1'b0, mio: 1'b0, wr: 1'b0,
               be_n: 4'hf, la: '0};
    forever begin
      #24 bclk_o = 1'b1;
      #24 bclk_o = 1'b0;
      if (stretch) #24;
    end
  end

  // A new start also ends a command still running, so cycles can run back to back.
  task automatic start_cycle(input logic wr, input logic mem, input logic [ADDR_W-1:0] addr,
                             input logic [BE_W-1:0] be_n, input logic slot_open,
                             input logic abort, input int waits);
    @(negedge bclk_o);
    pins_o.la <= addr;
    pins_o.be_n <= be_n;
    pins_o.mio <= mem;
    pins_o.wr <= wr;
    @(posedge bclk_o);
    pins_o.cmd_n <= 1'b1;
    pins_o.start_n <= 1'b0;
    pins_o.bale <= 1'b1;
    pins_o.aen <= mem | ~slot_open;
    @(posedge bclk_o);
    pins_o.start_n <= 1'b1;
    pins_o.bale <= 1'b0;
    pins_o.cmd_n <= abort;
    // Address and enables move on early, so only a latched copy stays right.
    pins_o.la <= ~addr;
    pins_o.be_n <= ~be_n;
    repeat (waits) @(posedge bclk_o);
  endtask

  task automatic end_cycle(input logic async_end);
    if (async_end) begin
      @(negedge bclk_o);
      #7;
    end else begin
      @(posedge bclk_o);
    end
    pins_o.cmd_n <= 1'b1;
    pins_o.aen <= 1'b1;
    pins_o.la <= pins_o.la ^ 30'h1555_5555;
    pins_o.be_n <= ~pins_o.be_n;
  endtask
endmodule

`default_nettype wire

/* test/eisa_cycle_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Testbench top
// ============================================================================
module eisa_cycle_ctrl_tb;
  import eisa_cycle_pkg::*;

  logic       clk;
  logic       rst_n;
  logic       bclk;
  link_pins_s pins;
  logic       cyc_valid;
  cycle_s     cyc;
  logic       busy;
  int         n_mismatch;
  int         samples_checked;
  logic       busy_seen;
  cycle_s     got_q[$];
  logic       cyc_valid_b;
  cycle_s     cyc_b;
  cycle_s     got_b[$];

  eisa_cycle_ctrl u_eisa_cycle_ctrl (
    .clk_i      (clk),
    .rst_n_i    (rst_n),
    .bclk_i     (bclk),
    .pins_i     (pins),
    .cyc_valid_o(cyc_valid),
    .cyc_o      (cyc),
    .busy_o     (busy)
  );

  // Second copy decodes from the BALE latch; it watches the same bus.
  eisa_cycle_ctrl #(
    .USE_BALE_LATCH (1'b1)
  ) u_eisa_cycle_ctrl_bale (
    .clk_i      (clk),
    .rst_n_i    (rst_n),
    .bclk_i     (bclk),
    .pins_i     (pins),
    .cyc_valid_o(cyc_valid_b),
    .cyc_o      (cyc_b),
    .busy_o     ()
  );

  eisa_board_model u_eisa_board_model (
    .bclk_o(bclk),
    .pins_o(pins)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cyc_valid === 1'b1) got_q.push_back(cyc);
    if (busy === 1'b1) busy_seen = 1'b1;
    if (cyc_valid_b === 1'b1) got_b.push_back(cyc_b);
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic clear();
    @(negedge clk);
    got_q.delete();
    got_b.delete();
    busy_seen = 1'b0;
  endtask

  // One framed cycle, then enough time for the crossing to deliver it.
  task automatic run(input logic wr, input logic mem, input logic [ADDR_W-1:0] addr,
                     input logic [BE_W-1:0] be_n, input logic open_slot, input logic abort,
                     input int waits, input logic async_end);
    clear();
    u_eisa_board_model.start_cycle(wr, mem, addr, be_n, open_slot, abort, waits);
    u_eisa_board_model.end_cycle(async_end);
    repeat (40) @(posedge clk);
  endtask

  function automatic cycle_s exp_cyc(logic wr, logic mem, logic [ADDR_W-1:0] a, logic [3:0] b);
    return '{write: wr, mem: mem, addr: a, be: ~b};
  endfunction

  task automatic t_io_hit();
    run(1'b1, 1'b0, IO_BASE_DEF + 30'h3, 4'h0, 1'b1, 1'b0, 1, 1'b0);
    check("io pulses", got_q.size(), 1);
    check("io cycle", got_q[0], exp_cyc(1'b1, 1'b0, IO_BASE_DEF + 30'h3, 4'h0));
    check("io busy", busy_seen, 1);
    $display("test io_hit done");
  endtask

  task automatic t_io_blocked();
    run(1'b1, 1'b0, IO_BASE_DEF, 4'h0, 1'b0, 1'b0, 1, 1'b0);
    check("blocked pulses", got_q.size(), 0);
    check("blocked busy", busy_seen, 1);
    $display("test io_blocked done");
  endtask

  task automatic t_mem_enables();
    logic [3:0] tbl[6] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3};
    for (int i = 0; i < 6; i++) begin
      run(1'b0, 1'b1, MEM_BASE_DEF + 30'(i * 5), tbl[i], 1'b0, 1'b0, i % 3, 1'b0);
      check("mem pulses", got_q.size(), 1);
      check("mem cycle", got_q[0], exp_cyc(1'b0, 1'b1, MEM_BASE_DEF + 30'(i * 5), tbl[i]));
    end
    $display("test mem_enables done");
  endtask

  task automatic t_stretch_async();
    u_eisa_board_model.stretch = 1'b1;
    run(1'b1, 1'b1, MEM_BASE_DEF + 30'h3_ffff, 4'h6, 1'b1, 1'b0, 2, 1'b1);
    u_eisa_board_model.stretch = 1'b0;
    check("stretch pulses", got_q.size(), 1);
    check("stretch cycle", got_q[0], exp_cyc(1'b1, 1'b1, MEM_BASE_DEF + 30'h3_ffff, 4'h6));
    run(1'b0, 1'b1, MEM_BASE_DEF, 4'h0, 1'b1, 1'b0, 1, 1'b1);
    check("after async", got_q.size(), 1);
    $display("test stretch_async done");
  endtask

  task automatic t_miss_abort();
    run(1'b0, 1'b1, 30'h0080_0000, 4'h0, 1'b1, 1'b0, 1, 1'b0);
    check("mem miss", got_q.size(), 0);
    run(1'b0, 1'b0, IO_BASE_DEF ^ 30'h10, 4'h0, 1'b1, 1'b0, 1, 1'b0);
    check("io miss", got_q.size(), 0);
    run(1'b1, 1'b0, IO_BASE_DEF, 4'h0, 1'b1, 1'b1, 1, 1'b0);
    check("abort pulses", got_q.size(), 0);
    check("abort busy", busy_seen, 0);
    $display("test miss_abort done");
  endtask

  task automatic t_back_to_back();
    clear();
    u_eisa_board_model.start_cycle(1'b1, 1'b0, IO_BASE_DEF + 30'h5, 4'h9, 1'b1, 1'b0, 1);
    u_eisa_board_model.start_cycle(1'b0, 1'b1, MEM_BASE_DEF + 30'h7, 4'h1, 1'b1, 1'b0, 1);
    u_eisa_board_model.end_cycle(1'b0);
    repeat (40) @(posedge clk);
    check("b2b pulses", got_q.size(), 2);
    check("b2b first", got_q[0], exp_cyc(1'b1, 1'b0, IO_BASE_DEF + 30'h5, 4'h9));
    check("b2b second", got_q[1], exp_cyc(1'b0, 1'b1, MEM_BASE_DEF + 30'h7, 4'h1));
    $display("test back_to_back done");
  endtask

  task automatic t_bale_latch();
    run(1'b0, 1'b1, MEM_BASE_DEF + 30'h11, 4'h5, 1'b0, 1'b0, 1, 1'b0);
    check("bale pulses", got_b.size(), 1);
    check("bale mem", got_b[0], exp_cyc(1'b0, 1'b1, MEM_BASE_DEF + 30'h11, 4'h5));
    run(1'b1, 1'b0, IO_BASE_DEF + 30'hc, 4'h3, 1'b1, 1'b0, 2, 1'b0);
    check("bale io pulses", got_b.size(), 1);
    check("bale io", got_b[0], exp_cyc(1'b1, 1'b0, IO_BASE_DEF + 30'hc, 4'h3));
    $display("test bale_latch done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // The bus side leaves reset a few bus clocks after release, so the first
  // cycle waits well beyond that.
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    busy_seen = 1'b0;
    rst_n = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge bclk);
    check("idle pulses", got_q.size(), 0);
    t_io_hit();
    t_io_blocked();
    t_mem_enables();
    t_stretch_async();
    t_miss_abort();
    t_back_to_back();
    t_bale_latch();
    results();
  end

  initial begin
    #200000;
    n_mismatch++;
    results();
  end
endmodule

`default_nettype wire
